// file: hdl/adcc_ctrl.sv
// Input configuration, sequencing and offset calibration control
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl #(
  parameter int ACQ_N = adcc_pkg::ACQ_TICKS,
  parameter int CONV_N = adcc_pkg::CONV_TICKS,
  parameter int CAL_N = adcc_pkg::CAL_TICKS
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic osc_clk_in,
  input wire logic [11:0] raw_code_in,
  output logic sample_switch_out,
  output logic cs1_sel_out,
  output logic cs2_sel_out,
  output logic busy_out,
  output logic irq_out
);

  // ***********************************
  // Helpers
  // ***********************************
  function automatic logic single_cfg(input logic [1:0] c);
    single_cfg = (c == adcc_pkg::CFG_ONE_SE) ||
                 (c == adcc_pkg::CFG_PSEUDO_DIFF);
  endfunction

  function automatic logic first_chan(input logic [1:0] l);
    first_chan = ~l[0];
  endfunction

  // ***********************************
  // Declarations
  // ***********************************
  adcc_code_if cif ();
  adcc_pkg::adcc_state_t state;
  adcc_pkg::adcc_state_t next_state;
  logic [1:0] input_config_sel;
  logic [2:0] operating_mode_sel;
  logic [1:0] sequence_channel_enable_reg;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] next_irq_status;
  logic [11:0] result0;
  logic [11:0] result1;
  logic signed [12:0] cal_offset;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic cur_chan;
  logic next_chan;
  logic [1:0] run_list;
  logic run_auto;
  logic cal_pend;
  logic stop_pend;
  logic osc_tick;
  logic [15:0] rd_mux;

  assign cif.raw = raw_code_in;
  assign cif.offset = cal_offset;

  adcc_pin_sync u_osc_sync (
    .clk_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .pin_in(osc_clk_in),
    .level_out(),
    .rise_out(osc_tick)
  );

  adcc_coder u_coder (
    .cif(cif.coder)
  );

  // ***********************************
  // Register decode
  // ***********************************
  wire wr_cfg = reg_wr_in && (reg_addr_in == adcc_pkg::ADDR_IN_CFG);
  wire wr_mode = reg_wr_in && (reg_addr_in == adcc_pkg::ADDR_OPMODE);
  wire wr_seq = reg_wr_in && (reg_addr_in == adcc_pkg::ADDR_SEQ_EN);
  wire wr_ctrl = reg_wr_in && (reg_addr_in == adcc_pkg::ADDR_CTRL);
  wire wr_istat = reg_wr_in && (reg_addr_in == adcc_pkg::ADDR_IRQ_STAT);
  wire wr_imask = reg_wr_in && (reg_addr_in == adcc_pkg::ADDR_IRQ_MASK);
  wire calibration_trigger =
    wr_ctrl && reg_wdata_in[adcc_pkg::CTRL_CAL_BIT];
  wire start_req = wr_ctrl && reg_wdata_in[adcc_pkg::CTRL_START_BIT];
  wire stop_req = wr_ctrl && reg_wdata_in[adcc_pkg::CTRL_STOP_BIT];

  // ***********************************
  // Mode and configuration decode
  // ***********************************
  wire two_ch = !single_cfg(input_config_sel);
  wire [1:0] next_in_cfg = wr_cfg ? reg_wdata_in[1:0] : input_config_sel;
  wire next_two_ch = !single_cfg(next_in_cfg);
  wire seq_err = !two_ch && sequence_channel_enable_reg[1];
  wire manual_ch0 = !operating_mode_sel[2];
  wire autonomous = (operating_mode_sel == adcc_pkg::MODE_AUTONOMOUS);
  wire [1:0] start_list =
    manual_ch0 ? 2'b01 : sequence_channel_enable_reg;
  wire idle_ok = (state == adcc_pkg::S_IDLE) && !cal_pend;
  wire start_ok = start_req && idle_ok && !seq_err &&
                  (start_list != 2'b00);
  wire err_ev = start_req && seq_err;
  wire acq_last = osc_tick && (cnt == 5'(ACQ_N - 1));
  wire conv_end = (state == adcc_pkg::S_CONV) && osc_tick &&
                  (cnt == 5'(CONV_N - 1));
  wire cal_end = (state == adcc_pkg::S_CAL) && osc_tick &&
                 (cnt == 5'(CAL_N - 1));
  wire more_ch1 = !cur_chan && run_list[1];
  wire [2:0] irq_ev;
  assign irq_ev[adcc_pkg::IRQ_DONE_BIT] = conv_end;
  assign irq_ev[adcc_pkg::IRQ_CAL_BIT] = cal_end;
  assign irq_ev[adcc_pkg::IRQ_ERR_BIT] = err_ev;
  assign next_irq_status =
    (irq_status & ~(wr_istat ? reg_wdata_in[2:0] : 3'h0)) | irq_ev;

  // ***********************************
  // Sequencer next state
  // ***********************************
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_chan = cur_chan;
    case (state)
      adcc_pkg::S_IDLE: begin
        if (cal_pend) begin
          next_state = adcc_pkg::S_CAL;
          next_cnt = 5'h0;
        end else if (start_ok) begin
          next_state = adcc_pkg::S_ACQ;
          next_cnt = 5'h0;
          next_chan = first_chan(start_list);
        end
      end
      adcc_pkg::S_ACQ: begin
        if (acq_last) begin
          next_state = adcc_pkg::S_CONV;
          next_cnt = 5'h0;
        end else if (osc_tick) begin
          next_cnt = cnt + 5'h1;
        end
      end
      adcc_pkg::S_CONV: begin
        if (conv_end) begin
          next_cnt = 5'h0;
          if (cal_pend || stop_pend) begin
            next_state = adcc_pkg::S_IDLE;
          end else if (more_ch1) begin
            next_state = adcc_pkg::S_ACQ;
            next_chan = 1'b1;
          end else if (run_auto) begin
            next_state = adcc_pkg::S_ACQ;
            next_chan = first_chan(run_list);
          end else begin
            next_state = adcc_pkg::S_IDLE;
          end
        end else if (osc_tick) begin
          next_cnt = cnt + 5'h1;
        end
      end
      adcc_pkg::S_CAL: begin
        if (cal_end) begin
          next_state = adcc_pkg::S_IDLE;
          next_cnt = 5'h0;
        end else if (osc_tick) begin
          next_cnt = cnt + 5'h1;
        end
      end
      default: begin
        next_state = adcc_pkg::S_IDLE;
        next_cnt = 5'h0;
      end
    endcase
  end

  // ***********************************
  // Sequencer state
  // ***********************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= adcc_pkg::S_IDLE;
      cnt <= 5'h0;
      cur_chan <= 1'b0;
      run_list <= 2'b01;
      run_auto <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cur_chan <= next_chan;
      if (start_ok) begin
        run_list <= start_list;
        run_auto <= autonomous;
      end
    end
  end

  // Pending calibration, armed out of reset; a new trigger wins
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cal_pend <= 1'b1;
      stop_pend <= 1'b0;
    end else begin
      cal_pend <= calibration_trigger ||
                  (cal_pend && !(state == adcc_pkg::S_IDLE));
      stop_pend <= stop_req ||
                   (stop_pend && !(state == adcc_pkg::S_IDLE));
    end
  end

  // ***********************************
  // Pin drive
  // ***********************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sample_switch_out <= 1'b0;
      cs1_sel_out <= 1'b0;
      cs2_sel_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      sample_switch_out <= (next_state == adcc_pkg::S_ACQ);
      cs1_sel_out <= next_two_ch && next_chan;
      cs2_sel_out <= !next_two_ch;
      busy_out <= (next_state != adcc_pkg::S_IDLE);
    end
  end

  // ***********************************
  // Results and offset
  // ***********************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result0 <= 12'h000;
      result1 <= 12'h000;
      cal_offset <= 13'sh0000;
    end else begin
      if (conv_end && !cur_chan) begin
        result0 <= cif.coded;
      end
      if (conv_end && cur_chan) begin
        result1 <= cif.coded;
      end
      if (cal_end) begin
        cal_offset <= $signed({1'b0, raw_code_in}) -
                      $signed({1'b0, adcc_pkg::MID_SCALE_CODE});
      end
    end
  end

  // ***********************************
  // Software registers and interrupt
  // ***********************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      input_config_sel <= adcc_pkg::RST_IN_CFG;
      operating_mode_sel <= adcc_pkg::RST_OPMODE;
      sequence_channel_enable_reg <= adcc_pkg::RST_SEQ_EN;
      irq_status <= 3'h0;
      irq_mask <= adcc_pkg::RST_IRQ_MASK;
      irq_out <= 1'b0;
    end else begin
      if (wr_cfg) begin
        input_config_sel <= reg_wdata_in[1:0];
      end
      if (wr_mode) begin
        operating_mode_sel <= reg_wdata_in[2:0];
      end
      if (wr_seq) begin
        sequence_channel_enable_reg <= reg_wdata_in[1:0];
      end
      if (wr_imask) begin
        irq_mask <= reg_wdata_in[2:0];
      end
      irq_status <= next_irq_status;
      irq_out <= |(irq_status & irq_mask);
    end
  end

  wire [15:0] seq_stat = {13'h0000, (state == adcc_pkg::S_CAL),
                          (state != adcc_pkg::S_IDLE), seq_err};
  assign rd_mux =
    (reg_addr_in == adcc_pkg::ADDR_IN_CFG) ? {14'h0000, input_config_sel} :
    (reg_addr_in == adcc_pkg::ADDR_OPMODE) ? {13'h0000, operating_mode_sel} :
    (reg_addr_in == adcc_pkg::ADDR_SEQ_EN) ?
      {14'h0000, sequence_channel_enable_reg} :
    (reg_addr_in == adcc_pkg::ADDR_SEQ_STAT) ? seq_stat :
    (reg_addr_in == adcc_pkg::ADDR_RES0) ? {4'h0, result0} :
    (reg_addr_in == adcc_pkg::ADDR_RES1) ? {4'h0, result1} :
    (reg_addr_in == adcc_pkg::ADDR_OFFSET) ? 16'(cal_offset) :
    (reg_addr_in == adcc_pkg::ADDR_IRQ_STAT) ? {13'h0000, irq_status} :
    (reg_addr_in == adcc_pkg::ADDR_IRQ_MASK) ? {13'h0000, irq_mask} :
    16'h0000;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 16'h0000;
    end
  end

  // ***********************************
  // Checks
  // ***********************************
  logic booted;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      booted <= 1'b0;
    end else if (cal_end) begin
      booted <= 1'b1;
    end
  end

  property p_switch_phase;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == adcc_pkg::S_ACQ) == sample_switch_out;
  endproperty
  a_switch_phase: assert property (p_switch_phase)
    else $error("Sampling switch disagrees with phase");

  property p_cal_busy;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == adcc_pkg::S_CAL) |-> busy_out && !sample_switch_out;
  endproperty
  a_cal_busy: assert property (p_cal_busy)
    else $error("Calibration without busy or with switch closed");

  property p_two_ch_ground;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (two_ch && state == adcc_pkg::S_ACQ) |->
      !cs2_sel_out && (cs1_sel_out == cur_chan);
  endproperty
  a_two_ch_ground: assert property (p_two_ch_ground)
    else $error("Two channel mux selection wrong");

  property p_single_pins;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (single_cfg(input_config_sel) && state == adcc_pkg::S_ACQ) |->
      !cs1_sel_out && cs2_sel_out;
  endproperty
  a_single_pins: assert property (p_single_pins)
    else $error("Single channel mux selection wrong");

  property p_err_refuse;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (start_req && seq_err && !wr_istat) |=>
      irq_status[adcc_pkg::IRQ_ERR_BIT] && state != adcc_pkg::S_ACQ;
  endproperty
  a_err_refuse: assert property (p_err_refuse)
    else $error("Bad sequence start not refused");

  property p_boot_cal;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !booted |-> (state == adcc_pkg::S_IDLE && cal_pend) ||
                state == adcc_pkg::S_CAL;
  endproperty
  a_boot_cal: assert property (p_boot_cal)
    else $error("Power-up calibration skipped");

  property p_ch_in_list;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == adcc_pkg::S_ACQ) |-> run_list[cur_chan];
  endproperty
  a_ch_in_list: assert property (p_ch_in_list)
    else $error("Converting a channel not in the sequence");

  property p_result_capture;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (conv_end && !cur_chan) |=> result0 == $past(cif.coded);
  endproperty
  a_result_capture: assert property (p_result_capture)
    else $error("Channel 0 result not captured");

  property p_auto_wrap;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (conv_end && run_auto && !more_ch1 && !cal_pend && !stop_pend) |=>
      state == adcc_pkg::S_ACQ && sample_switch_out;
  endproperty
  a_auto_wrap: assert property (p_auto_wrap)
    else $error("Autonomous sequence did not restart");

  property p_manual_ch0;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (start_ok && manual_ch0) |=> state == adcc_pkg::S_ACQ && !cur_chan
      ##1 run_list == 2'b01;
  endproperty
  a_manual_ch0: assert property (p_manual_ch0)
    else $error("Manual mode did not convert channel 0 only");

  c_cal_done: cover property (@(posedge clk_sys_in) cal_end);
  c_seq_err: cover property (@(posedge clk_sys_in) err_ev);
  c_ch1_done: cover property (@(posedge clk_sys_in) conv_end && cur_chan);
  c_auto_wrap: cover property (@(posedge clk_sys_in)
    conv_end && run_auto && !more_ch1);

endmodule // adcc_ctrl
`default_nettype wire

// file: common/adcc_pkg.sv
// Shared constants and types for the converter control block
package adcc_pkg;

  // ***********************************
  // Register bus widths and offsets
  // ***********************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADDR_IN_CFG = 4'h0;
  localparam logic [3:0] ADDR_OPMODE = 4'h1;
  localparam logic [3:0] ADDR_SEQ_EN = 4'h2;
  localparam logic [3:0] ADDR_CTRL = 4'h3;
  localparam logic [3:0] ADDR_SEQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_RES0 = 4'h5;
  localparam logic [3:0] ADDR_RES1 = 4'h6;
  localparam logic [3:0] ADDR_OFFSET = 4'h7;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;

  // ***********************************
  // Field positions
  // ***********************************
  localparam int CTRL_CAL_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_CAL_BIT = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_CAL_BIT = 1;
  localparam int IRQ_ERR_BIT = 2;
  localparam int IRQ_W = 3;

  // ***********************************
  // Field encodings and reset values
  // ***********************************
  localparam logic [1:0] CFG_TWO_SE_A = 2'h0;
  localparam logic [1:0] CFG_ONE_SE = 2'h1;
  localparam logic [1:0] CFG_PSEUDO_DIFF = 2'h2;
  localparam logic [1:0] CFG_TWO_SE_B = 2'h3;
  localparam logic [2:0] MODE_MAN_CH0_A = 3'h0;
  localparam logic [2:0] MODE_MAN_SEQ_A = 3'h4;
  localparam logic [2:0] MODE_AUTONOMOUS = 3'h6;
  localparam logic [2:0] MODE_HIGH_PREC = 3'h7;
  localparam logic [1:0] RST_IN_CFG = 2'h0;
  localparam logic [2:0] RST_OPMODE = 3'h0;
  localparam logic [1:0] RST_SEQ_EN = 2'h0;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

  // ***********************************
  // Output coding
  // ***********************************
  localparam int RES_W = 12;
  localparam logic [11:0] NEGATIVE_FULL_SCALE = 12'h000;
  localparam logic [11:0] MID_SCALE_CODE = 12'h800;
  localparam logic [11:0] POSITIVE_FULL_SCALE = 12'hFFF;

  // ***********************************
  // Timing in oscillator periods
  // ***********************************
  localparam int ACQ_TICKS = 4;
  localparam int CONV_TICKS = 14;
  localparam int CAL_TICKS = 16;
  localparam int CNT_W = 5;

  typedef enum logic [1:0] {S_IDLE, S_ACQ, S_CONV, S_CAL} adcc_state_t;

endpackage

// file: common/adcc_code_if.sv
// Carrier between the sequencer and the output coder
`timescale 1ns/1ps
`default_nettype none
interface adcc_code_if;
  logic [11:0] raw;
  logic signed [12:0] offset;
  logic [11:0] coded;
  modport ctrl (output raw, output offset, input coded);
  modport coder (input raw, input offset, output coded);
endinterface
`default_nettype wire

// file: hdl/adcc_pin_sync.sv
// Three stage synchroniser with edge finding for an outside input
`timescale 1ns/1ps
`default_nettype none
module adcc_pin_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_out <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_out <= s3;
      end
      rise_out <= s2 & s3 & ~level_out;
    end
  end
endmodule // adcc_pin_sync
`default_nettype wire

// file: hdl/adcc_coder.sv
// Offset correction and straight binary saturation of a raw code
`timescale 1ns/1ps
`default_nettype none
module adcc_coder (
  adcc_code_if.coder cif
);
  function automatic logic [11:0] sat_code(input logic signed [13:0] d);
    if (d < 14'sd0) begin
      sat_code = adcc_pkg::NEGATIVE_FULL_SCALE;
    end else if (d > 14'sd4095) begin
      sat_code = adcc_pkg::POSITIVE_FULL_SCALE;
    end else begin
      sat_code = d[11:0];
    end
  endfunction

  logic signed [13:0] diff;
  assign diff = $signed({2'b00, cif.raw}) - 14'(cif.offset);
  assign cif.coded = sat_code(diff);
endmodule // adcc_coder
`default_nettype wire

// file: tb/adcc_analog_model.sv
// Analog core stand-in: conversion oscillator and raw code source
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
  input wire logic [11:0] level_in,
  input wire logic sw_in,
  output logic osc_clk_out,
  output logic [11:0] raw_code_out
);
  // ***********************************
  // Oscillator, 200 ns, unrelated phase
  // ***********************************
  initial begin
    osc_clk_out = 1'b0;
    #37;
    forever #100 osc_clk_out = ~osc_clk_out;
  end
  // Code is only meaningful with switches open
  assign raw_code_out = sw_in ? ~level_in : level_in;
endmodule // adcc_analog_model
`default_nettype wire

// file: tb/adcc_ctrl_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_bench;
  logic clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in, osc_clk_in;
  logic sample_switch_out, cs1_sel_out, cs2_sel_out, busy_out, irq_out;
  logic [3:0] reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out;
  logic [11:0] raw_code_in, level;
  logic sw_q, sw_q2, in_cal;
  logic [1:0] seen[$];
  int exp_q[$];
  int n_fail, total_checks, off_m;
  logic [15:0] v;

  adcc_ctrl #(.ACQ_N(2), .CONV_N(2), .CAL_N(2)) adcc_ctrl_i (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .osc_clk_in(osc_clk_in),
    .raw_code_in(raw_code_in), .sample_switch_out(sample_switch_out),
    .cs1_sel_out(cs1_sel_out), .cs2_sel_out(cs2_sel_out),
    .busy_out(busy_out), .irq_out(irq_out));
  adcc_analog_model adcc_analog_model_i (.level_in(level),
    .sw_in(sample_switch_out), .osc_clk_out(osc_clk_in),
    .raw_code_out(raw_code_in));

  // ***********************************
  // Clock, monitor, watchdog
  // ***********************************
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    sw_q <= sample_switch_out;
    sw_q2 <= sw_q;
    if (sw_q && !sw_q2) seen.push_back({cs1_sel_out, cs2_sel_out});
    if (in_cal && sample_switch_out) begin
      n_fail++;
      $display("BAD switch expected 0 seen 1");
    end
  end
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    n_fail++;
    complete_run();
  end

  // ***********************************
  // Tasks
  // ***********************************
  task automatic complete_run();
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask
  task automatic wait_idle();
    int i;
    i = 0;
    repeat (2) @(posedge clk_sys_in);
    #1;
    while (busy_out !== 1'b0 && i < 3000) begin
      @(posedge clk_sys_in);
      #1;
      i++;
    end
    chk("idle", 16'h0, {15'h0, busy_out});
  endtask
  function automatic logic [15:0] coded(input logic [11:0] r);
    int x;
    x = int'(r) - off_m;
    if (x < 0) x = 0;
    if (x > 4095) x = 4095;
    return 16'(x);
  endfunction
  task automatic cal(input logic [11:0] r);
    level = r;
    wr(adcc_pkg::ADDR_CTRL, 16'h0001);
    in_cal = 1'b1;
    @(posedge clk_sys_in);
    #1;
    chk("cal busy", 16'h1, {15'h0, busy_out});
    wait_idle();
    in_cal = 1'b0;
    off_m = int'(r) - 2048;
    rd(adcc_pkg::ADDR_OFFSET, v);
    chk("offset", 16'(off_m), v);
  endtask
  task automatic run_seq(input logic [1:0] c, input logic [2:0] m,
      input logic [1:0] en, input logic [11:0] r);
    level = r;
    wr(adcc_pkg::ADDR_IN_CFG, {14'h0, c});
    wr(adcc_pkg::ADDR_OPMODE, {13'h0, m});
    wr(adcc_pkg::ADDR_SEQ_EN, {14'h0, en});
    seen.delete();
    exp_q.delete();
    if (m < 3'h4 || en[0]) exp_q.push_back(0);
    if (m >= 3'h4 && en[1]) exp_q.push_back(1);
    wr(adcc_pkg::ADDR_CTRL, 16'h0002);
    wait_idle();
    chk("switch", 16'h0, {15'h0, sample_switch_out});
    chk("chans", 16'(exp_q.size()), 16'(seen.size()));
    foreach (exp_q[k]) begin
      if (k < seen.size()) begin
        chk("cs1", 16'(exp_q[k]), {15'h0, seen[k][1]});
        chk("cs2", {15'h0, c == 2'h1 || c == 2'h2},
          {15'h0, seen[k][0]});
      end
      rd(exp_q[k] == 1 ? adcc_pkg::ADDR_RES1 : adcc_pkg::ADDR_RES0, v);
      chk("result", coded(r), v);
    end
  endtask

  // ***********************************
  // Main sequence
  // ***********************************
  initial begin
    logic [2:0] modes[4];
    modes = '{3'h1, 3'h4, 3'h5, 3'h7};
    void'($urandom(59));
    rst_n_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 16'h0000;
    level = 12'h805;
    in_cal = 1'b0;
    sw_q = 1'b0;
    sw_q2 = 1'b0;
    repeat (4) @(posedge clk_sys_in);
    chk("rst busy", 16'h0, {15'h0, busy_out});
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    in_cal = 1'b1;
    #1;
    chk("powerup cal", 16'h1, {15'h0, busy_out});
    rd(adcc_pkg::ADDR_IN_CFG, v);
    chk("cfg", 16'h0, v);
    rd(adcc_pkg::ADDR_OPMODE, v);
    chk("mode", 16'h0, v);
    rd(adcc_pkg::ADDR_SEQ_EN, v);
    chk("seq", 16'h0, v);
    rd(adcc_pkg::ADDR_IRQ_MASK, v);
    chk("mask", 16'h0, v);
    rd(4'hA, v);
    chk("unmapped", 16'h0, v);
    wait_idle();
    in_cal = 1'b0;
    off_m = 5;
    rd(adcc_pkg::ADDR_OFFSET, v);
    chk("offset", 16'h0005, v);
    run_seq(2'h0, 3'h0, 2'h3, 12'h003);
    foreach (modes[i]) run_seq(2'(i), modes[i], (i % 3 == 0) ? 2'h3 : 2'h1,
      12'($urandom % 4096));
    run_seq(2'h3, 3'h4, 2'h2, 12'($urandom % 4096));
    run_seq(2'h1, 3'h4, 2'h1, 12'($urandom % 4096));
    run_seq(2'h2, 3'h5, 2'h1, 12'h800);
    cal(12'h7F0);
    run_seq(2'h0, 3'h4, 2'h3, 12'hFF8);
    // Autonomous repeats until stopped
    run_seq(2'h0, 3'h6, 2'h0, 12'h123);
    wr(adcc_pkg::ADDR_SEQ_EN, 16'h0001);
    seen.delete();
    wr(adcc_pkg::ADDR_CTRL, 16'h0002);
    repeat (300) @(posedge clk_sys_in);
    chk("auto busy", 16'h1, {15'h0, busy_out});
    chk("auto runs", 16'h1, {15'h0, seen.size() > 1});
    wr(adcc_pkg::ADDR_CTRL, 16'h0004);
    wait_idle();
    rd(adcc_pkg::ADDR_RES0, v);
    chk("auto result", coded(12'h123), v);
    // Bad configuration, refused start, interrupt
    wr(adcc_pkg::ADDR_IRQ_STAT, 16'h0007);
    rd(adcc_pkg::ADDR_IRQ_STAT, v);
    chk("irq clr", 16'h0, v);
    wr(adcc_pkg::ADDR_IRQ_MASK, 16'h0004);
    wr(adcc_pkg::ADDR_IN_CFG, 16'h0001);
    wr(adcc_pkg::ADDR_OPMODE, 16'h0004);
    wr(adcc_pkg::ADDR_SEQ_EN, 16'h0003);
    rd(adcc_pkg::ADDR_SEQ_STAT, v);
    chk("err flag", 16'h0001, v);
    wr(adcc_pkg::ADDR_CTRL, 16'h0002);
    repeat (3) @(posedge clk_sys_in);
    chk("refused", 16'h0, {15'h0, busy_out});
    rd(adcc_pkg::ADDR_IRQ_STAT, v);
    chk("irq err", 16'h0004, v);
    chk("irq on", 16'h1, {15'h0, irq_out});
    wr(adcc_pkg::ADDR_IRQ_MASK, 16'h0000);
    repeat (2) @(posedge clk_sys_in);
    chk("irq masked", 16'h0, {15'h0, irq_out});
    wr(adcc_pkg::ADDR_IRQ_MASK, 16'h0004);
    wr(adcc_pkg::ADDR_IRQ_STAT, 16'h0004);
    repeat (2) @(posedge clk_sys_in);
    chk("irq cleared", 16'h0, {15'h0, irq_out});
    complete_run();
  end
endmodule // adcc_ctrl_bench
`default_nettype wire
